// >>> include/sbst_pkg.sv
// Behaviour
// - inputs taken on test clock rise, outputs launched on its fall
// - tms sampled on each rise steers controller; reads high when undriven
// - current instruction picks the scan register between tdi and tdo
// - tdi enters the msb, tdo leaves from the lsb of every register
// - tdo driven only in shift states, else high-z, changes on fall
// - five rises with tms high reach reset, memory operation untouched
// - power-up reset puts controller in reset with tdo high-z
// - exactly one scan register sits in the serial path at a time
// - instruction register is three bits, shifted in from tdi
// - reset state and power-up load the identification instruction
// - capture-ir loads 01 into the two low instruction bits
// - bypass is one bit between tdi and tdo, cleared on capture
// - boundary register captures pin ring in capture-dr, shifts in shift-dr
// - extest, sample/preload and sample-z make boundary capture the ring
// - identification register captures fixed 32-bit code, shifts it out
// - sample-z floats output bus until next instruction update
// - cell 108 gates output bus in extest; preset high at reset
package sbst_pkg;

  // ==========================================================
  // controller states, gray along the usual path
  typedef enum logic [3:0] {
    TAP_RESET    = 4'h0, TAP_IDLE     = 4'h1, TAP_SEL_DR   = 4'h3,
    TAP_CAP_DR   = 4'h2, TAP_SHIFT_DR = 4'h6, TAP_EX1_DR   = 4'h7,
    TAP_PAUSE_DR = 4'h5, TAP_EX2_DR   = 4'h4, TAP_UPD_DR   = 4'hc,
    TAP_SEL_IR   = 4'hd, TAP_CAP_IR   = 4'hf, TAP_SHIFT_IR = 4'he,
    TAP_EX1_IR   = 4'ha, TAP_PAUSE_IR = 4'hb, TAP_EX2_IR   = 4'h9,
    TAP_UPD_IR   = 4'h8
  } sbst_tap_type;

  // data register selection
  typedef enum logic [1:0] {
    SEL_BYP = 2'h0, SEL_ID = 2'h1, SEL_BSR = 2'h2
  } sbst_sel_type;

  // ==========================================================
  // scan geometry and instruction codes
  localparam int          IR_LEN     = 3;
  localparam int          ID_LEN     = 32;
  localparam int          BSR_LEN    = 109;
  localparam int          OE_CELL    = 108;
  localparam logic [2:0]  IR_EXTEST  = 3'h0;
  localparam logic [2:0]  IR_IDCODE  = 3'h1;
  localparam logic [2:0]  IR_SAMPZ   = 3'h2;
  localparam logic [2:0]  IR_SAMPLE  = 3'h4;
  localparam logic [2:0]  IR_BYPASS  = 3'h7;
  localparam logic [2:0]  IR_CAPTURE = 3'h1;
  // arbitrary value, lsb set as a valid id needs
  localparam logic [31:0] ID_CODE    = 32'h0a5a_5001;
  localparam logic [2:0]  TMS_RESET_EDGES = 3'h5;

  // ==========================================================
  // register bus map
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam int         CTRL_SRST  = 0;
  localparam int         STAT_STATE = 0;
  localparam int         STAT_IR    = 4;
  localparam int         STAT_QOE   = 7;
  localparam int         STAT_EXT   = 8;
  localparam int         STAT_TDOE  = 9;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } sbst_av_req_type;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } sbst_av_rsp_type;

endpackage

// >>> design/sbst_tap.sv
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module sbst_tap (
  input  wire logic                           core_clk,
  input  wire logic                           nrst,
  input  wire logic                           tck,
  input  wire logic                           tms,
  input  wire logic                           tdi,
  output logic                                tdo,
  output logic                                tdo_oe,
  input  wire logic [sbst_pkg::BSR_LEN-1:0]   pin_ring,
  output logic      [sbst_pkg::BSR_LEN-1:0]   bsr_drive,
  output logic                                q_bus_oe,
  output logic                                extest_active,
  input  wire sbst_pkg::sbst_av_req_type      av_req,
  output sbst_pkg::sbst_av_rsp_type           av_rsp
);

  // ==========================================================
  // state record
  typedef struct packed {
    logic [1:0]                  tck_sy;
    logic                        tck_d;
    logic [1:0]                  tms_sy;
    logic [1:0]                  tdi_sy;
    sbst_pkg::sbst_tap_type      state;
    logic [2:0]                  ir_sh;
    logic [2:0]                  ir;
    logic                        byp;
    logic [31:0]                 id_sh;
    logic [sbst_pkg::BSR_LEN-1:0] bsr_sh;
    logic [sbst_pkg::BSR_LEN-1:0] bsr_upd;
    logic                        tdo;
    logic                        tdo_oe;
    logic                        q_oe;
    logic                        ext;
    logic                        wait_r;
    logic [31:0]                 rdata;
  } sbst_state_type;

  sbst_state_type st;
  sbst_state_type next_st;
  logic           rise;
  logic           fall;
  logic           tms_v;
  logic           tdi_v;

  // ==========================================================
  // controller transition
  function automatic sbst_pkg::sbst_tap_type next_tap(
    input sbst_pkg::sbst_tap_type s,
    input logic                   m
  );
    next_tap = s;
    unique case (s)
      sbst_pkg::TAP_RESET:
        next_tap = m ? sbst_pkg::TAP_RESET : sbst_pkg::TAP_IDLE;
      sbst_pkg::TAP_IDLE:
        next_tap = m ? sbst_pkg::TAP_SEL_DR : sbst_pkg::TAP_IDLE;
      sbst_pkg::TAP_SEL_DR:
        next_tap = m ? sbst_pkg::TAP_SEL_IR : sbst_pkg::TAP_CAP_DR;
      sbst_pkg::TAP_CAP_DR:
        next_tap = m ? sbst_pkg::TAP_EX1_DR : sbst_pkg::TAP_SHIFT_DR;
      sbst_pkg::TAP_SHIFT_DR:
        next_tap = m ? sbst_pkg::TAP_EX1_DR : sbst_pkg::TAP_SHIFT_DR;
      sbst_pkg::TAP_EX1_DR:
        next_tap = m ? sbst_pkg::TAP_UPD_DR : sbst_pkg::TAP_PAUSE_DR;
      sbst_pkg::TAP_PAUSE_DR:
        next_tap = m ? sbst_pkg::TAP_EX2_DR : sbst_pkg::TAP_PAUSE_DR;
      sbst_pkg::TAP_EX2_DR:
        next_tap = m ? sbst_pkg::TAP_UPD_DR : sbst_pkg::TAP_SHIFT_DR;
      sbst_pkg::TAP_UPD_DR:
        next_tap = m ? sbst_pkg::TAP_SEL_DR : sbst_pkg::TAP_IDLE;
      sbst_pkg::TAP_SEL_IR:
        next_tap = m ? sbst_pkg::TAP_RESET : sbst_pkg::TAP_CAP_IR;
      sbst_pkg::TAP_CAP_IR:
        next_tap = m ? sbst_pkg::TAP_EX1_IR : sbst_pkg::TAP_SHIFT_IR;
      sbst_pkg::TAP_SHIFT_IR:
        next_tap = m ? sbst_pkg::TAP_EX1_IR : sbst_pkg::TAP_SHIFT_IR;
      sbst_pkg::TAP_EX1_IR:
        next_tap = m ? sbst_pkg::TAP_UPD_IR : sbst_pkg::TAP_PAUSE_IR;
      sbst_pkg::TAP_PAUSE_IR:
        next_tap = m ? sbst_pkg::TAP_EX2_IR : sbst_pkg::TAP_PAUSE_IR;
      sbst_pkg::TAP_EX2_IR:
        next_tap = m ? sbst_pkg::TAP_UPD_IR : sbst_pkg::TAP_SHIFT_IR;
      sbst_pkg::TAP_UPD_IR:
        next_tap = m ? sbst_pkg::TAP_SEL_DR : sbst_pkg::TAP_IDLE;
    endcase
  endfunction

  // reserved codes fall back to bypass so the path never opens
  function automatic sbst_pkg::sbst_sel_type sel_of(input logic [2:0] i);
    if (i == sbst_pkg::IR_IDCODE) begin
      sel_of = sbst_pkg::SEL_ID;
    end else if (i == sbst_pkg::IR_EXTEST || i == sbst_pkg::IR_SAMPZ ||
                 i == sbst_pkg::IR_SAMPLE) begin
      sel_of = sbst_pkg::SEL_BSR;
    end else begin
      sel_of = sbst_pkg::SEL_BYP;
    end
  endfunction

  function automatic logic is_shift(input sbst_pkg::sbst_tap_type s);
    is_shift = (s == sbst_pkg::TAP_SHIFT_DR) ||
               (s == sbst_pkg::TAP_SHIFT_IR);
  endfunction

  // ==========================================================
  // test clock edges, seen after the second sync stage only
  assign rise  = st.tck_sy[1] & ~st.tck_d;
  assign fall  = ~st.tck_sy[1] & st.tck_d;
  assign tms_v = st.tms_sy[1];
  assign tdi_v = st.tdi_sy[1];

  // ==========================================================
  // next-state logic
  always_comb begin
    next_st        = st;
    next_st.tck_sy = {st.tck_sy[0], tck};
    next_st.tck_d  = st.tck_sy[1];
    next_st.tms_sy = {st.tms_sy[0], tms};
    next_st.tdi_sy = {st.tdi_sy[0], tdi};
    next_st.wait_r = 1'b1;
    if (rise) begin
      next_st.state = next_tap(st.state, tms_v);
      if (st.state == sbst_pkg::TAP_CAP_IR) begin
        next_st.ir_sh = sbst_pkg::IR_CAPTURE;
      end else if (st.state == sbst_pkg::TAP_SHIFT_IR) begin
        next_st.ir_sh = {tdi_v, st.ir_sh[2:1]};
      end else if (st.state == sbst_pkg::TAP_UPD_IR) begin
        next_st.ir = st.ir_sh;
      end else if (st.state == sbst_pkg::TAP_CAP_DR) begin
        unique case (sel_of(st.ir))
          sbst_pkg::SEL_BYP: next_st.byp = 1'b0;
          sbst_pkg::SEL_ID:  next_st.id_sh = sbst_pkg::ID_CODE;
          sbst_pkg::SEL_BSR: next_st.bsr_sh = pin_ring;
          default: next_st.byp = 1'b0;
        endcase
      end else if (st.state == sbst_pkg::TAP_SHIFT_DR) begin
        unique case (sel_of(st.ir))
          sbst_pkg::SEL_BYP: next_st.byp = tdi_v;
          sbst_pkg::SEL_ID:
            next_st.id_sh = {tdi_v, st.id_sh[31:1]};
          sbst_pkg::SEL_BSR:
            next_st.bsr_sh = {tdi_v, st.bsr_sh[sbst_pkg::BSR_LEN-1:1]};
          default: next_st.byp = tdi_v;
        endcase
      end else if (st.state == sbst_pkg::TAP_UPD_DR &&
                   sel_of(st.ir) == sbst_pkg::SEL_BSR) begin
        // preload latch feeds the pin drivers
        next_st.bsr_upd = st.bsr_sh;
      end
    end
    if (fall) begin
      // tdo launched on fall, driven in shift only
      next_st.tdo_oe = is_shift(st.state);
      if (st.state == sbst_pkg::TAP_SHIFT_IR) begin
        next_st.tdo = st.ir_sh[0];
      end else if (sel_of(st.ir) == sbst_pkg::SEL_ID) begin
        next_st.tdo = st.id_sh[0];
      end else if (sel_of(st.ir) == sbst_pkg::SEL_BSR) begin
        next_st.tdo = st.bsr_sh[0];
      end else begin
        next_st.tdo = st.byp;
      end
    end
    if (st.state == sbst_pkg::TAP_RESET) begin
      // reset state holds id and enables output bus
      next_st.ir = sbst_pkg::IR_IDCODE;
      next_st.bsr_upd[sbst_pkg::OE_CELL] = 1'b1;
      next_st.tdo_oe = 1'b0;
    end
    // output bus gating from current instruction
    next_st.ext  = (st.ir == sbst_pkg::IR_EXTEST);
    next_st.q_oe = (st.ir == sbst_pkg::IR_EXTEST) ?
                   st.bsr_upd[sbst_pkg::OE_CELL] :
                   (st.ir != sbst_pkg::IR_SAMPZ);
    // bus slave: one wait cycle, answer on the second
    if ((av_req.read || av_req.write) && st.wait_r) begin
      next_st.wait_r = 1'b0;
      next_st.rdata  = 32'h0000_0000;
      if (av_req.read && av_req.address == sbst_pkg::OFS_STATUS) begin
        next_st.rdata[sbst_pkg::STAT_STATE +: 4] = st.state;
        next_st.rdata[sbst_pkg::STAT_IR +: 3]    = st.ir;
        next_st.rdata[sbst_pkg::STAT_QOE]        = st.q_oe;
        next_st.rdata[sbst_pkg::STAT_EXT]        = st.ext;
        next_st.rdata[sbst_pkg::STAT_TDOE]       = st.tdo_oe;
      end
    end
    // soft reset lands on the edge that completes the write
    if (!st.wait_r && av_req.write &&
        av_req.address == sbst_pkg::OFS_CTRL && av_req.byteenable[0] &&
        av_req.writedata[sbst_pkg::CTRL_SRST]) begin
      next_st.state = sbst_pkg::TAP_RESET;
    end
  end

  // ==========================================================
  // state register; power-up reset puts tdo in high-z
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st         <= '0;
      st.tms_sy  <= 2'h3;
      st.tdi_sy  <= 2'h3;
      st.state   <= sbst_pkg::TAP_RESET;
      st.ir      <= sbst_pkg::IR_IDCODE;
      st.bsr_upd <= {1'b1, {(sbst_pkg::BSR_LEN-1){1'b0}}};
      st.q_oe    <= 1'b1;
      st.wait_r  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the record
  assign tdo                = st.tdo;
  assign tdo_oe             = st.tdo_oe;
  assign bsr_drive          = st.bsr_upd;
  assign q_bus_oe           = st.q_oe;
  assign extest_active      = st.ext;
  assign av_rsp.waitrequest = st.wait_r;
  assign av_rsp.readdata    = st.rdata;

  // ==========================================================
  // checks
  logic [2:0] hi_cnt;

  // consecutive rises seen with tms high, saturating
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt <= 3'h0;
    end else if (rise) begin
      if (!tms_v) begin
        hi_cnt <= 3'h0;
      end else if (hi_cnt != sbst_pkg::TMS_RESET_EDGES) begin
        hi_cnt <= hi_cnt + 3'h1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_TMS_FIVE: assert property (
    (hi_cnt == sbst_pkg::TMS_RESET_EDGES) |->
      st.state == sbst_pkg::TAP_RESET)
    else $error("five tms-high rises did not reach reset");
  AST_TDO_OE: assert property (
    fall |=> st.tdo_oe == (is_shift($past(st.state)) &&
                           $past(st.state) != sbst_pkg::TAP_RESET))
    else $error("tdo enable does not follow shift state");
  AST_TDO_FALL: assert property (
    (!fall && st.state != sbst_pkg::TAP_RESET) |=>
      $stable(st.tdo) && $stable(st.tdo_oe))
    else $error("tdo changed away from a falling edge");
  AST_CAP_IR: assert property (
    (rise && st.state == sbst_pkg::TAP_CAP_IR) |=> st.ir_sh[1:0] == 2'b01)
    else $error("capture-ir pattern wrong");
  AST_RESET_ID: assert property (
    (st.state == sbst_pkg::TAP_RESET) |=> st.ir == sbst_pkg::IR_IDCODE)
    else $error("reset state did not load id instruction");
  AST_BYP_CLR: assert property (
    (rise && st.state == sbst_pkg::TAP_CAP_DR &&
     st.ir == sbst_pkg::IR_BYPASS) |=> !st.byp)
    else $error("bypass not cleared on capture");
  AST_BSR_SHIFT: assert property (
    (rise && st.state == sbst_pkg::TAP_SHIFT_DR &&
     sel_of(st.ir) == sbst_pkg::SEL_BSR) |=>
      st.bsr_sh == {$past(tdi_v), $past(st.bsr_sh[sbst_pkg::BSR_LEN-1:1])})
    else $error("boundary shift not msb-in lsb-out");
  AST_RING_CAP: assert property (
    (rise && st.state == sbst_pkg::TAP_CAP_DR &&
     sel_of(st.ir) == sbst_pkg::SEL_BSR) |=> st.bsr_sh == $past(pin_ring))
    else $error("pin ring not captured");
  AST_ID_CAP: assert property (
    (rise && st.state == sbst_pkg::TAP_CAP_DR &&
     st.ir == sbst_pkg::IR_IDCODE) |=> st.id_sh == sbst_pkg::ID_CODE)
    else $error("id code not captured");
  AST_SAMPZ: assert property (
    (st.ir == sbst_pkg::IR_SAMPZ) [*2] |-> !st.q_oe)
    else $error("sample-z left output bus enabled");
  AST_EXT_CELL: assert property (
    (st.ir == sbst_pkg::IR_EXTEST) |=>
      st.q_oe == $past(st.bsr_upd[sbst_pkg::OE_CELL]))
    else $error("extest bus enable not from gating cell");
  AST_IR_HOLD: assert property (
    (!(rise && st.state == sbst_pkg::TAP_UPD_IR) &&
     st.state != sbst_pkg::TAP_RESET) |=> $stable(st.ir))
    else $error("instruction changed outside update-ir");

  COV_UPD_IR: cover property (rise && st.state == sbst_pkg::TAP_UPD_IR);
  COV_ID_OUT: cover property (st.tdo_oe && st.ir == sbst_pkg::IR_IDCODE);
  COV_SAMPZ:  cover property (st.ir == sbst_pkg::IR_SAMPZ && !st.q_oe);
  COV_RESET5: cover property (hi_cnt == sbst_pkg::TMS_RESET_EDGES);

endmodule
`default_nettype wire

// >>> dv/sbst_host.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// board test controller model: link clock 32 ns, runs in frames
module sbst_host (
  input  wire logic     core_clk,
  input  wire logic     tdo,
  input  wire logic     tdo_oe,
  output logic          tck,
  output logic          tms,
  output logic          tdi,
  output logic          done,
  output logic [127:0]  dout
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    done = 1'b0;
    dout = '0;
  end

  // one link cycle; tdo read late in high phase, it stands to the fall
  task automatic step(input logic m, input logic d, output logic q);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge core_clk);
    tck <= 1'b1;
    repeat (4) @(posedge core_clk);
    q = tdo_oe ? tdo : 1'bx;
  endtask

  task automatic park();
    tck <= 1'b0;
    tms <= 1'b1;
    tdi <= 1'b1;
    @(posedge core_clk);
  endtask

  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    park();
  endtask

  task automatic scan(input logic ir, input int n, input logic [127:0] din);
    logic [127:0] v;
    logic         q;
    v = '0;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      v[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    dout <= v;
    done <= 1'b1;
    park();
    done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/sbst_tap_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// self-checking bench: host model on the link, master on the bus
module sbst_tap_tb;
  logic                          core_clk, nrst, tck, tms, tdi, tdo;
  logic                          tdo_oe, q_bus_oe, extest_active;
  logic [sbst_pkg::BSR_LEN-1:0]  pin_ring, bsr_drive;
  sbst_pkg::sbst_av_req_type     av_req;
  sbst_pkg::sbst_av_rsp_type     av_rsp;
  logic                          host_done;
  logic [127:0]                  host_dout, w;
  logic [2:0]                    codes [3];
  int                            error_cnt, comparisons;
  logic [31:0]                   lfsr_state;
  logic [31:0]                   exp_rd [$];
  logic [127:0]                  exp_sc [$];

  sbst_tap dut_u (.core_clk(core_clk), .nrst(nrst), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_ring(pin_ring),
    .bsr_drive(bsr_drive), .q_bus_oe(q_bus_oe),
    .extest_active(extest_active), .av_req(av_req), .av_rsp(av_rsp));
  sbst_host host_u (.core_clk(core_clk), .tdo(tdo), .tdo_oe(tdo_oe),
    .tck(tck), .tms(tms), .tdi(tdi), .done(host_done), .dout(host_dout));

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    lfsr_state = {lfsr_state[30:0], 1'b0}
      ^ (lfsr_state[31] ? 32'h8020_0003 : 32'h0000_0000);
    return lfsr_state;
  endfunction

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("counts: %0d compared, %0d mismatched", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one bus cycle; an edge passes first so release and raise never meet
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    av_req.read <= !wr;
    av_req.write <= wr;
    av_req.address <= a;
    av_req.writedata <= d;
    av_req.byteenable <= 4'hf;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (av_rsp.waitrequest !== 1'b0 && k < 50);
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic ir_load(input logic [2:0] c);
    exp_sc.push_back(128'(sbst_pkg::IR_CAPTURE));
    host_u.scan(1'b1, sbst_pkg::IR_LEN, 128'(c));
  endtask

  // ==========================================================
  // watcher: each result met takes the oldest note
  always @(posedge core_clk) begin
    if (av_req.read === 1'b1 && av_rsp.waitrequest === 1'b0
        && exp_rd.size() > 0) begin
      check(128'(av_rsp.readdata), 128'(exp_rd.pop_front()));
    end
    if (host_done === 1'b1 && exp_sc.size() > 0) begin
      check(host_dout, exp_sc.pop_front());
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    av_req = '0;
    pin_ring = '0;
    lfsr_state = 32'h0000_579f;
    error_cnt = 0;
    comparisons = 0;
    codes = '{sbst_pkg::IR_SAMPLE, sbst_pkg::IR_EXTEST, sbst_pkg::IR_SAMPZ};
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    check(128'(tdo_oe), 128'h0);
    check(128'(bsr_drive), 128'(1) << sbst_pkg::OE_CELL);
    rd(sbst_pkg::OFS_STATUS, 32'h0000_0090);
    $display("test power-up done");
    // capture pattern, then bypass shifts one stage late
    host_u.tap_reset();
    ir_load(sbst_pkg::IR_BYPASS);
    w = 128'(rnd());
    exp_sc.push_back(128'({w[6:0], 1'b0}));
    host_u.scan(1'b0, 8, w);
    rd(sbst_pkg::OFS_STATUS, 32'h0000_00f1);
    $display("test bypass done");
    // tms reset restores the identification instruction
    host_u.tap_reset();
    rd(sbst_pkg::OFS_STATUS, 32'h0000_0091);
    exp_sc.push_back(128'(sbst_pkg::ID_CODE));
    host_u.scan(1'b0, sbst_pkg::ID_LEN, 128'(rnd()));
    $display("test ident done");
    // boundary capture under each boundary instruction, update checked under sample/preload only
    for (int i = 0; i < 3; i++) begin
      w = {rnd(), rnd(), rnd(), rnd()};
      pin_ring <= w[108:0];
      ir_load(codes[i]);
      exp_sc.push_back(128'(w[108:0]));
      w = {rnd(), rnd(), rnd(), rnd()} & ~(128'(1) << sbst_pkg::OE_CELL);
      host_u.scan(1'b0, sbst_pkg::BSR_LEN, w);
      check(128'(tdo_oe), 128'h0);
      check(128'(q_bus_oe), 128'(i == 0));
      check(128'(extest_active), 128'(i == 1));
      if (i == 0) check(128'(bsr_drive), 128'(w[108:0]));
    end
    host_u.tap_reset();
    check(128'(q_bus_oe), 128'h1);
    check(128'(bsr_drive[sbst_pkg::OE_CELL]), 128'h1);
    $display("test boundary done");
    // soft reset over the bus, refused places read zero
    ir_load(sbst_pkg::IR_BYPASS);
    bus(1'b1, sbst_pkg::OFS_CTRL, 32'h0000_0001);
    rd(sbst_pkg::OFS_STATUS, 32'h0000_0090);
    rd(sbst_pkg::OFS_CTRL, 32'h0000_0000);
    bus(1'b1, 4'h8, 32'hffff_ffff);
    rd(4'h8, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    check(128'(exp_rd.size() + exp_sc.size()), 128'h0);
    $display("test bus done");
    wrap_up();
  end
endmodule
`default_nettype wire
